// ==== wdtm_pkg.sv ====
// Purpose: shared constants and types of the watchdog timeout monitor
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes: offsets are byte addresses, one word per register
package wdtm_pkg;

  localparam int unsigned ADDR_W = 5;

  // register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CLKC = 5'h04;
  localparam logic [4:0] OFF_TAKEY = 5'h08;
  localparam logic [4:0] OFF_ISTAT = 5'h0c;
  localparam logic [4:0] OFF_ICLR = 5'h10;
  localparam logic [4:0] OFF_IEN = 5'h14;
  localparam logic [4:0] OFF_INTEN = 5'h18;

  // watchdog_control fields
  localparam int unsigned TOF_BIT = 3;
  localparam int unsigned RCF_BIT = 2;
  localparam int unsigned REN_BIT = 1;
  localparam int unsigned RST_BIT = 0;

  // clock_control interval select field
  localparam int unsigned SEL_LO_BIT = 6;
  localparam int unsigned SEL_HI_BIT = 7;
  localparam logic [7:0] CLKC_RST = 8'h00;

  // interrupt enable register fields
  localparam int unsigned EIE_WDT_BIT = 4;
  localparam int unsigned GIE_BIT = 7;
  localparam logic [7:0] INTEN_RST = 8'h00;

  // sticky status / enable / clear layout
  localparam int unsigned IRQ_TMO_BIT = 0;
  localparam int unsigned IRQ_WRST_BIT = 1;
  localparam int unsigned IRQ_W = 2;

  // timed access
  localparam logic [7:0] TA_KEY1 = 8'haa;
  localparam logic [7:0] TA_KEY2 = 8'h55;
  localparam logic [3:0] TA_WIN_CYC = 4'h8;

  // divider: 26 bits, taps 16,19,22,25
  localparam int unsigned DIV_W = 26;
  localparam int unsigned DIV_TAP_BASE = 16;
  localparam int unsigned DIV_TAP_STEP = 3;

  // grace period after a time-out, and reset pulse length
  localparam int unsigned POST_CYC = 512;
  localparam logic [8:0] POST_LAST = 9'(POST_CYC - 1);
  localparam int unsigned MC_CLKS = 4;
  localparam logic [3:0] RST_CYC = 4'(2 * MC_CLKS);

  typedef enum logic [2:0] {
    WDTM_TA_IDLE = 3'b001,
    WDTM_TA_KEY1 = 3'b010,
    WDTM_TA_OPEN = 3'b100
  } wdtm_ta_t;

endpackage : wdtm_pkg

// ==== wdtm_sync.sv ====
// Purpose: three-stage synchroniser for an asynchronous pin
// Assumes: pin level is slow compared with clk
// Notes: output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module wdtm_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule : wdtm_sync
`default_nettype wire

// ==== wdtm_divider.sv ====
// Purpose: free-running 26-bit divider with selectable time-out tap
// Assumes: clear is a synchronous restart from the control logic
// Notes: timeout_q is a one-cycle pulse, 2^(tap+1) clocks after clear
`timescale 1ns/10ps
`default_nettype none
module wdtm_divider #(
  parameter int unsigned TAP_BASE = wdtm_pkg::DIV_TAP_BASE
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic [1:0] sel,
  output logic timeout_q
);
  logic [wdtm_pkg::DIV_W-1:0] cnt_q;
  logic [wdtm_pkg::DIV_W-1:0] cnt_d;
  logic [wdtm_pkg::DIV_W-1:0] low_mask;
  logic [4:0] tap_w;
  logic done_w;

  assign tap_w = 5'(TAP_BASE) + 5'(wdtm_pkg::DIV_TAP_STEP * sel);

  for (genvar i = 0; i < wdtm_pkg::DIV_W; i++) begin : g_mask
    assign low_mask[i] = (5'(i) <= tap_w);
  end
  assign done_w = &(cnt_q | ~low_mask);

  assign cnt_d = clear ? '0 : cnt_q + 26'h1;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      timeout_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      timeout_q <= done_w & ~clear;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  tmo_spacing_a: assert property (timeout_q |=> !timeout_q [*8])
    else $error("time-out pulses too close together");
  tmo_after_clear_a: assert property (clear |=> !timeout_q [*8])
    else $error("time-out right after a restart");
endmodule : wdtm_divider
`default_nettype wire

// ==== wdtm_top.sv ====
// Purpose: watchdog timeout monitor with Avalon-MM register slave
// Assumes: sys_rst is the power-on reset; power_fail is an async pin
// Notes: every access answers with one wait cycle
`timescale 1ns/10ps
`default_nettype none
// How it works
// - a free-running divider counts clocks and yields the time-out event
// - interval select 00..11 gives 2^17, 2^20, 2^23, 2^26 clocks
// - after any reset the interval select returns to 2^17 clocks
// - every completed interval sets the time-out flag
// - interrupt request while flag, watchdog enable and global enable are set
// - interrupt and reset paths are enabled independently
// - reset fires 512 clocks after time-out unless restarted, if enabled
// - watchdog reset lasts two machine cycles and sets the cause flag
// - writing restart clears the counter; the bit clears itself
// - clearing reset enable stops only the reset; counting goes on
// - power-fail disables the watchdog; watchdog reset only restarts it
// - time-out flag clears only by software write or any reset
// - cause flag holds until software or power-fail; untouched when disabled
// - time-out flag, reset enable, restart need the timed-access unlock
module wdtm_top #(
  parameter int unsigned TAP_BASE = wdtm_pkg::DIV_TAP_BASE
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [wdtm_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic power_fail,
  output logic wdt_int_req,
  output logic wdt_sys_rst,
  output logic irq
);
  // bus handshake
  logic ack_q;
  logic req_w;
  logic wr_fire;
  logic rd_take;
  logic [31:0] rdata_w;

  // address decode
  logic hit_ctrl;
  logic hit_clkc;
  logic hit_ta;
  logic hit_istat;
  logic hit_iclr;
  logic hit_ien;
  logic hit_inten;

  // timed access
  wdtm_pkg::wdtm_ta_t ta_q;
  wdtm_pkg::wdtm_ta_t ta_d;
  logic [3:0] win_q;
  logic [3:0] win_d;
  logic key1_w;
  logic key2_w;
  logic ta_open;
  logic ctrl_wr;
  logic prot_wr;

  // watchdog state
  logic pf_q;
  logic tmo;
  logic div_clear;
  logic restart_q;
  logic tof_q;
  logic rcf_q;
  logic ren_q;
  logic [7:0] clkc_q;
  logic [7:0] inten_q;
  logic post_q;
  logic [8:0] post_cnt_q;
  logic fire;
  logic rst_act_q;
  logic [3:0] rst_cnt_q;
  logic any_rst;
  logic [7:0] ctrl_view;

  // interrupt status
  logic [wdtm_pkg::IRQ_W-1:0] ist_q;
  logic [wdtm_pkg::IRQ_W-1:0] ien_q;
  logic [wdtm_pkg::IRQ_W-1:0] ist_set;
  logic [wdtm_pkg::IRQ_W-1:0] ist_clr;

  wdtm_sync u_pf_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(power_fail),
    .level_q(pf_q)
  );

  wdtm_divider #(
    .TAP_BASE(TAP_BASE)
  ) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(div_clear),
    .sel(clkc_q[wdtm_pkg::SEL_HI_BIT:wdtm_pkg::SEL_LO_BIT]),
    .timeout_q(tmo)
  );

  // one wait cycle per access; write lands and read data stand at the ack edge
  assign req_w = avs_read | avs_write;
  assign avs_waitrequest = req_w & ~ack_q;
  assign wr_fire = avs_write & ack_q;
  assign rd_take = avs_read & ~ack_q;

  assign hit_ctrl = (avs_address == wdtm_pkg::OFF_CTRL);
  assign hit_clkc = (avs_address == wdtm_pkg::OFF_CLKC);
  assign hit_ta = (avs_address == wdtm_pkg::OFF_TAKEY);
  assign hit_istat = (avs_address == wdtm_pkg::OFF_ISTAT);
  assign hit_iclr = (avs_address == wdtm_pkg::OFF_ICLR);
  assign hit_ien = (avs_address == wdtm_pkg::OFF_IEN);
  assign hit_inten = (avs_address == wdtm_pkg::OFF_INTEN);

  assign key1_w = wr_fire & hit_ta & (avs_writedata[7:0] == wdtm_pkg::TA_KEY1);
  assign key2_w = wr_fire & hit_ta & (avs_writedata[7:0] == wdtm_pkg::TA_KEY2);
  assign ta_open = (ta_q == wdtm_pkg::WDTM_TA_OPEN);
  assign ctrl_wr = wr_fire & hit_ctrl;
  // protected fields only inside the window
  assign prot_wr = ctrl_wr & ta_open;

  always_comb begin
    ta_d = ta_q;
    win_d = win_q;
    case (ta_q)
      wdtm_pkg::WDTM_TA_IDLE: begin
        if (key1_w) begin
          ta_d = wdtm_pkg::WDTM_TA_KEY1;
        end
      end
      wdtm_pkg::WDTM_TA_KEY1: begin
        if (key2_w) begin
          ta_d = wdtm_pkg::WDTM_TA_OPEN;
          win_d = wdtm_pkg::TA_WIN_CYC;
        end else if (wr_fire & ~key1_w) begin
          ta_d = wdtm_pkg::WDTM_TA_IDLE;
        end
      end
      wdtm_pkg::WDTM_TA_OPEN: begin
        win_d = win_q - 4'h1;
        // one protected write per unlock
        if (ctrl_wr || win_q == 4'h1) begin
          ta_d = wdtm_pkg::WDTM_TA_IDLE;
        end
      end
      default: begin
        ta_d = wdtm_pkg::WDTM_TA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ta_q <= wdtm_pkg::WDTM_TA_IDLE;
      win_q <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      ta_q <= ta_d;
      win_q <= win_d;
      ack_q <= req_w & ~ack_q;
    end
  end

  // fire after the grace period, if enabled and not restarted
  assign fire = post_q & (post_cnt_q == wdtm_pkg::POST_LAST) & ren_q & ~restart_q & ~pf_q;
  // watchdog reset and power-fail both restart the count
  assign div_clear = restart_q | fire | rst_act_q | pf_q;
  assign any_rst = rst_act_q | pf_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= prot_wr & avs_writedata[wdtm_pkg::RST_BIT];
    end
  end

  // grace period counter after each time-out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      post_q <= 1'b0;
      post_cnt_q <= 9'h0;
    end else if (div_clear) begin
      post_q <= 1'b0;
      post_cnt_q <= 9'h0;
    end else if (tmo) begin
      post_q <= 1'b1;
      post_cnt_q <= 9'h0;
    end else if (post_q) begin
      post_q <= (post_cnt_q != wdtm_pkg::POST_LAST);
      post_cnt_q <= post_cnt_q + 9'h1;
    end
  end

  // reset pulse of two machine cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_act_q <= 1'b0;
      rst_cnt_q <= 4'h0;
    end else if (fire) begin
      rst_act_q <= 1'b1;
      rst_cnt_q <= wdtm_pkg::RST_CYC;
    end else if (rst_act_q) begin
      rst_act_q <= (rst_cnt_q != 4'h1);
      rst_cnt_q <= rst_cnt_q - 4'h1;
    end
  end
  assign wdt_sys_rst = rst_act_q;

  // time-out flag; cleared only by reset or software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tof_q <= 1'b0;
    end else if (any_rst) begin
      tof_q <= 1'b0;
    end else if (tmo) begin
      tof_q <= 1'b1;
    end else if (prot_wr) begin
      tof_q <= avs_writedata[wdtm_pkg::TOF_BIT];
    end
  end

  // cause flag: set on fire, cleared by software or power-fail
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rcf_q <= 1'b0;
    end else if (pf_q) begin
      rcf_q <= 1'b0;
    end else if (fire) begin
      rcf_q <= 1'b1;
    end else if (ctrl_wr && !avs_writedata[wdtm_pkg::RCF_BIT]) begin
      rcf_q <= 1'b0;
    end
  end

  // reset enable gates only the fire; power-fail disables
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ren_q <= 1'b0;
    end else if (pf_q) begin
      ren_q <= 1'b0;
    end else if (prot_wr) begin
      ren_q <= avs_writedata[wdtm_pkg::REN_BIT];
    end
  end

  // interval select back to shortest on any reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkc_q <= wdtm_pkg::CLKC_RST;
      inten_q <= wdtm_pkg::INTEN_RST;
    end else if (any_rst) begin
      clkc_q <= wdtm_pkg::CLKC_RST;
      inten_q <= wdtm_pkg::INTEN_RST;
    end else begin
      if (wr_fire & hit_clkc) begin
        clkc_q <= avs_writedata[7:0];
      end
      if (wr_fire & hit_inten) begin
        inten_q <= avs_writedata[7:0];
      end
    end
  end

  // request needs flag, watchdog enable and global enable
  assign wdt_int_req = tof_q & inten_q[wdtm_pkg::EIE_WDT_BIT] & inten_q[wdtm_pkg::GIE_BIT];

  // sticky status: a set in the clearing cycle wins
  assign ist_set[wdtm_pkg::IRQ_TMO_BIT] = tmo;
  assign ist_set[wdtm_pkg::IRQ_WRST_BIT] = fire;
  assign ist_clr = (wr_fire & hit_iclr) ? avs_writedata[wdtm_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ist_q <= '0;
      ien_q <= '0;
    end else begin
      ist_q <= (ist_q & ~ist_clr) | ist_set;
      if (wr_fire & hit_ien) begin
        ien_q <= avs_writedata[wdtm_pkg::IRQ_W-1:0];
      end
    end
  end
  assign irq = |(ist_q & ien_q);

  // restart bit reads back until it self clears
  assign ctrl_view = {4'h0, tof_q, rcf_q, ren_q, restart_q};
  assign rdata_w = hit_ctrl ? {24'h00_0000, ctrl_view} :
                   hit_clkc ? {24'h00_0000, clkc_q} :
                   hit_istat ? {30'h000_0000, ist_q} :
                   hit_ien ? {30'h000_0000, ien_q} :
                   hit_inten ? {24'h00_0000, inten_q} : 32'h0000_0000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata <= rdata_w;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_tmo_armed;
    tmo && ren_q && !pf_q && !restart_q;
  endsequence

  sequence s_rst_pulse;
    wdt_sys_rst [*8] ##1 !wdt_sys_rst;
  endsequence

  tof_set_a: assert property (tmo && !any_rst |=> tof_q)
    else $error("time-out did not set the flag");
  int_req_a: assert property (tmo && !any_rst && inten_q[4] && inten_q[7] |=> wdt_int_req)
    else $error("enabled time-out gave no interrupt request");
  grace_hold_a: assert property (s_tmo_armed |=> !wdt_sys_rst [*8])
    else $error("reset came before the grace period");
  fire_delay_a: assert property ($rose(wdt_sys_rst) |-> $past(post_cnt_q) == 9'h1ff)
    else $error("reset not 512 clocks after time-out");
  rst_len_a: assert property ($rose(wdt_sys_rst) |-> s_rst_pulse)
    else $error("watchdog reset length wrong");
  cause_set_a: assert property ($rose(wdt_sys_rst) |-> rcf_q)
    else $error("cause flag not set by watchdog reset");
  cause_guard_a: assert property ($rose(rcf_q) |-> $past(ren_q))
    else $error("cause flag set while reset disabled");
  restart_self_a: assert property (restart_q |=> !restart_q && !post_q)
    else $error("restart bit did not clear itself");
  locked_ren_a: assert property (ctrl_wr && !ta_open && !pf_q |=> $stable(ren_q))
    else $error("locked write changed reset enable");
  pf_disable_a: assert property (pf_q |=> !ren_q && !tof_q && !rcf_q)
    else $error("power-fail left the watchdog armed");
  tof_hold_a: assert property (tof_q && !any_rst && !prot_wr |=> tof_q)
    else $error("time-out flag cleared by itself");
  sel_default_a: assert property (rst_act_q |=> clkc_q[7:6] == 2'b00)
    else $error("interval select not back to shortest");
endmodule : wdtm_top
`default_nettype wire

// ==== wdtm_tb.sv ====
// Purpose: self-checking bench of the watchdog timeout monitor
// Assumes: TAP_BASE set to 10, so select 00 times out after 2^11 clocks
// Notes: expected intervals and reset length derive from TAP and MC_CLKS; the grace period is checked as a literal 512
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  localparam int unsigned TAP = 10;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [wdtm_pkg::ADDR_W-1:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic power_fail = 1'b0;
  logic wdt_int_req;
  logic wdt_sys_rst;
  logic irq;
  logic rst_seen = 1'b0;
  logic [31:0] seed = 32'h0000_b156;
  int fails = 0;
  int n_tests = 0;
  int cnt;

  always #5 clk = ~clk;

  wdtm_top #(.TAP_BASE(TAP)) u_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .power_fail(power_fail),
    .wdt_int_req(wdt_int_req),
    .wdt_sys_rst(wdt_sys_rst),
    .irq(irq)
  );

  // sticky so a short reset pulse between polls is never missed
  always @(posedge clk) if (wdt_sys_rst === 1'b1) rst_seen <= 1'b1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic int interval(input int sel);
    return 1 << (TAP + 1 + 3 * sel);
  endfunction : interval

  task automatic test_done();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 20) begin
      fails++;
      test_done();
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask : rdc

  task automatic prot(input logic [31:0] d);
    wr(wdtm_pkg::OFF_TAKEY, {24'h00_0000, wdtm_pkg::TA_KEY1});
    wr(wdtm_pkg::OFF_TAKEY, {24'h00_0000, wdtm_pkg::TA_KEY2});
    wr(wdtm_pkg::OFF_CTRL, d);
  endtask : prot

  // counts edges until irq (or the watchdog reset) is seen high
  task automatic wait_hi(input bit use_rst, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (((use_rst ? wdt_sys_rst : irq) !== 1'b1) && c < lim);
    if (c >= lim) begin
      fails++;
      test_done();
    end
  endtask : wait_hi

  // restart-to-flag latency has a few clocks of pipeline slack
  task automatic near(input int c, input int e);
    `CHK(c >= e - 3 && c <= e + 3, 1'b1)
  endtask : near

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    `CHK({wdt_int_req, wdt_sys_rst, irq}, 3'b000)
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0000);
    rdc(wdtm_pkg::OFF_CLKC, 32'h0000_0000);
    rdc(wdtm_pkg::OFF_INTEN, 32'h0000_0000);
    rdc(5'h1c, 32'h0000_0000);
    // every select code plus random clock_control values
    for (int k = 0; k < 12; k++) begin
      seed = xs(seed);
      if (k < 4) seed[7:6] = k[1:0];
      wr(wdtm_pkg::OFF_CLKC, seed);
      wr(5'h1c, ~seed);
      rdc(wdtm_pkg::OFF_CLKC, {24'h00_0000, seed[7:0]});
    end
    wr(wdtm_pkg::OFF_CLKC, 32'h0000_0000);
    // protected bits stay put without the unlock
    wr(wdtm_pkg::OFF_CTRL, 32'h0000_000b);
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0000);
    // expired window, then a key pair broken by another write
    wr(wdtm_pkg::OFF_TAKEY, {24'h00_0000, wdtm_pkg::TA_KEY1});
    wr(wdtm_pkg::OFF_TAKEY, {24'h00_0000, wdtm_pkg::TA_KEY2});
    repeat (10) @(posedge clk);
    wr(wdtm_pkg::OFF_CTRL, 32'h0000_000b);
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0000);
    wr(wdtm_pkg::OFF_TAKEY, {24'h00_0000, wdtm_pkg::TA_KEY1});
    wr(wdtm_pkg::OFF_CLKC, 32'h0000_0000);
    wr(wdtm_pkg::OFF_TAKEY, {24'h00_0000, wdtm_pkg::TA_KEY2});
    wr(wdtm_pkg::OFF_CTRL, 32'h0000_000b);
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0000);
    wr(wdtm_pkg::OFF_IEN, 32'h0000_0001);
    prot(32'h0000_0001);
    wait_hi(0, 3000, cnt);
    near(cnt, interval(0) + 1);
    repeat (50) @(posedge clk);
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0008);
    // both enables needed for the request
    for (int m = 0; m < 4; m++) begin
      wr(wdtm_pkg::OFF_INTEN, {24'h00_0000, m[1], 2'b00, m[0], 4'h0});
      #1;
      `CHK(wdt_int_req, m == 3)
    end
    wr(wdtm_pkg::OFF_ICLR, 32'h0000_0001);
    #1;
    `CHK(irq, 1'b0)
    wr(wdtm_pkg::OFF_CTRL, 32'h0000_0000);
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0008);
    prot(32'h0000_0000);
    #1;
    `CHK(wdt_int_req, 1'b0)
    wait_hi(0, 2200, cnt);
    `CHK(wdt_int_req, 1'b1)
    wr(wdtm_pkg::OFF_IEN, 32'h0000_0000);
    #1;
    `CHK(irq, 1'b0)
    rdc(wdtm_pkg::OFF_ISTAT, 32'h0000_0001);
    wr(wdtm_pkg::OFF_ICLR, 32'h0000_0003);
    wr(wdtm_pkg::OFF_IEN, 32'h0000_0001);
    wr(wdtm_pkg::OFF_CLKC, 32'h0000_0040);
    prot(32'h0000_0003);
    wait_hi(0, 20000, cnt);
    near(cnt, interval(1) + 1);
    wait_hi(1, 600, cnt);
    `CHK(cnt, 512)
    cnt = 0;
    while (wdt_sys_rst === 1'b1 && cnt < 20) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    `CHK(cnt, 2 * wdtm_pkg::MC_CLKS)
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0006);
    rdc(wdtm_pkg::OFF_CLKC, 32'h0000_0000);
    rdc(wdtm_pkg::OFF_ISTAT, 32'h0000_0003);
    wr(wdtm_pkg::OFF_IEN, 32'h0000_0002);
    #1;
    `CHK(irq, 1'b1)
    // restart inside the grace period cancels the reset
    wr(wdtm_pkg::OFF_ICLR, 32'h0000_0003);
    wr(wdtm_pkg::OFF_IEN, 32'h0000_0001);
    wait_hi(0, 2200, cnt);
    repeat (300) @(posedge clk);
    prot(32'h0000_0003);
    rst_seen = 1'b0;
    repeat (600) @(posedge clk);
    `CHK(rst_seen, 1'b0)
    wr(wdtm_pkg::OFF_CTRL, 32'h0000_0000);
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0002);
    prot(32'h0000_0001);
    wr(wdtm_pkg::OFF_ICLR, 32'h0000_0003);
    rst_seen = 1'b0;
    wait_hi(0, 2200, cnt);
    repeat (600) @(posedge clk);
    `CHK(rst_seen, 1'b0)
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0008);
    // power-fail clears cause and disables the watchdog
    prot(32'h0000_0003);
    wait_hi(1, 3000, cnt);
    repeat (12) @(posedge clk);
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0006);
    @(posedge clk);
    power_fail <= 1'b1;
    repeat (10) @(posedge clk);
    power_fail <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(wdtm_pkg::OFF_CTRL, 32'h0000_0000);
    rst_seen = 1'b0;
    repeat (3000) @(posedge clk);
    `CHK(rst_seen, 1'b0)
    test_done();
  end
endmodule : testbench
`default_nettype wire
